// ===== hdl/hpm_pkg.sv
// Purpose: shared types and constants for the host port pin mode select block
// Assumes: single 250 MHz clock, synchronous active-high reset
// Notes:   bit positions of the shared bus pins are named here, not in the logic
package hpm_pkg;

  typedef enum logic [1:0] {
    HPM_MODE_MUX    = 2'h0,
    HPM_MODE_NONMUX = 2'h1,
    HPM_MODE_SERIAL = 2'h2,
    HPM_MODE_HW     = 2'h3
  } hpm_mode_t;

  localparam int HPM_BUS_W      = 8;
  localparam int HPM_BIT_RXTERM = 7;
  localparam int HPM_BIT_TXTERM = 6;
  localparam int HPM_BIT_RXM1   = 5;
  localparam int HPM_BIT_RXM0   = 4;
  localparam int HPM_BIT_TSYNC  = 3;
  localparam int HPM_BIT_RSYNC  = 2;
  localparam int HPM_BIT_SCLK   = 2;
  localparam int HPM_BIT_RXM3   = 1;
  localparam int HPM_BIT_MOSI   = 1;
  localparam int HPM_BIT_TCS0   = 0;
  localparam int HPM_BIT_MISO   = 0;

  localparam logic [7:0] HPM_BUS_ZERO = 8'h00;

  // hardware-mode configuration captured from the straps
  typedef struct packed {
    logic       rx_term_disable;
    logic       tx_term_disable;
    logic       rx_mode_sel_3;
    logic       rx_mode_sel_1;
    logic       rx_mode_sel_0;
    logic       tx_sync_function_sel;
    logic       rx_sync_function_sel;
    logic       tx_mode_sel_2;
    logic       tx_mode_sel_1;
    logic       tx_mode_sel_0;
    logic       jitter_clk_sel;
    logic [1:0] tx_clk_source_sel;
  } hpm_hw_cfg_t;

  localparam hpm_hw_cfg_t HPM_HW_CFG_RESET = '0;

  // parallel/serial bus side seen by the register core
  typedef struct packed {
    logic       sclk;
    logic       mosi;
    logic [7:0] bus_in;
  } hpm_host_in_t;

endpackage : hpm_pkg

// ===== hdl/hpm_alert_drv.sv
// Purpose: open-drain active-low alert pin driver
// Assumes: external pull-up holds the wire high when not driven
// Notes:   output data is always zero; only the enable moves
`timescale 1ns/1ns
module hpm_alert_drv (
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_event,
  input  wire logic i_tristate,
  output logic      o_alert_n_out,
  output logic      o_alert_n_oe
);

  logic enable_q;

  // registered enable so the pin never glitches on event decode
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= i_event & ~i_tristate; // [RL1] [RL5]
    end
  end

  assign o_alert_n_out = 1'b0;                 // [RL19]
  assign o_alert_n_oe  = enable_q & ~i_tristate; // [RL19] [RL5]

endmodule : hpm_alert_drv

// ===== hdl/hpm_pin_mux.sv
// Purpose: host port pin role selection, strap capture, alert and tristate/reset pin
// Assumes: all pins synchronous to i_clock; straps static after reset
// Notes:   register core and serial engine live elsewhere; this block only steers pins
//
// Overview of operation
// RL1: alert pin pulls low while any status event is pending; the code never pulls it in hardware mode or before the straps are sampled.
// RL2: strapper drives jitter clock select high for T1 with high-rate master clock.
// RL3: in hardware mode transmit mode comes from transmit mode select pins.
// RL4: rising tristate/reset pin resets configuration registers to defaults.
// RL5: tristate/reset high floats every output; outside holds it low normally.
// RL6: two-bit strap picks muxed, nonmuxed, serial or hardware mode.
// RL7: strap 01 makes shared pins the nonmultiplexed data bus.
// RL8: strap 00 makes shared pins the multiplexed address/data bus.
// RL9: hardware mode bit 7 disables receive termination.
// RL10: hardware mode bit 6 disables transmit termination.
// RL11: hardware mode bits 5, 4, 1 give receive mode bits 1, 0, 3.
// RL12: hardware mode bit 3 picks transmit sync, bit 2 receive sync function.
// RL13: serial mode bit 2 is the serial clock input.
// RL14: serial mode bit 1 is serial data input from host.
// RL15: strap 10 makes bit 0 the serial data output.
// RL16: transmit clock source from bit 0 and dedicated select 1 input.
// RL17: host holds chip select low during every access.
// RL18: strap and hardware settings are sampled after reset and held.
// RL19: alert pin only pulls low, otherwise floats on external pull-up.
`timescale 1ns/1ns
module hpm_pin_mux (
  input  wire logic                 i_clock,
  input  wire logic                 i_reset,
  // straps and dedicated pins
  input  wire logic [1:0]           i_host_port_mode,
  input  wire logic                 i_tristate_and_reset,
  input  wire logic                 i_tx_mode_sel_1,
  input  wire logic                 i_tx_mode_sel_2,
  input  wire logic                 i_tx_mode_sel_0,
  input  wire logic                 i_tx_clk_source_sel_1,
  input  wire logic                 i_chip_select_n,
  // shared bus pins, three signals each
  input  wire logic [7:0]           i_bus_pin_in,
  output logic      [7:0]           o_bus_pin_out,
  output logic      [7:0]           o_bus_pin_oe,
  // alert / jitter clock select pin
  input  wire logic                 i_alert_pin_in,
  output logic                      o_alert_n_out,
  output logic                      o_alert_n_oe,
  // core side
  input  wire logic                 i_status_event,
  input  wire logic [7:0]           i_core_rd_data,
  input  wire logic                 i_core_rd_drive,
  input  wire logic                 i_core_miso,
  output hpm_pkg::hpm_mode_t        o_mode,
  output hpm_pkg::hpm_hw_cfg_t      o_hw_cfg,
  output hpm_pkg::hpm_host_in_t     o_host_in,
  output logic                      o_chip_select_n,
  output logic                      o_config_reset,
  output logic                      o_tristate
);

  hpm_pkg::hpm_mode_t   mode_q;
  hpm_pkg::hpm_hw_cfg_t hw_cfg_q;
  hpm_pkg::hpm_hw_cfg_t hw_cfg_d;
  hpm_pkg::hpm_host_in_t host_in_q;
  logic                 sampled_q;
  logic                 tst_prev_q;
  logic                 cfg_reset_q;
  logic                 tristate_q;
  logic                 cs_n_q;
  logic [7:0]           out_d;
  logic [7:0]           oe_d;
  logic [7:0]           out_q;
  logic [7:0]           oe_q;
  logic                 alert_event;

  function automatic logic is_mode(input hpm_pkg::hpm_mode_t m,
                                   input hpm_pkg::hpm_mode_t want);
    is_mode = (m == want);
  endfunction : is_mode

  // gather hardware-mode fields straight from the pins
  always_comb begin
    hw_cfg_d                      = hpm_pkg::HPM_HW_CFG_RESET;
    hw_cfg_d.rx_term_disable      = i_bus_pin_in[hpm_pkg::HPM_BIT_RXTERM]; // [RL9]
    hw_cfg_d.tx_term_disable      = i_bus_pin_in[hpm_pkg::HPM_BIT_TXTERM]; // [RL10]
    hw_cfg_d.rx_mode_sel_1        = i_bus_pin_in[hpm_pkg::HPM_BIT_RXM1];   // [RL11]
    hw_cfg_d.rx_mode_sel_0        = i_bus_pin_in[hpm_pkg::HPM_BIT_RXM0];   // [RL11]
    hw_cfg_d.rx_mode_sel_3        = i_bus_pin_in[hpm_pkg::HPM_BIT_RXM3];   // [RL11]
    hw_cfg_d.tx_sync_function_sel = i_bus_pin_in[hpm_pkg::HPM_BIT_TSYNC];  // [RL12]
    hw_cfg_d.rx_sync_function_sel = i_bus_pin_in[hpm_pkg::HPM_BIT_RSYNC];  // [RL12]
    hw_cfg_d.tx_mode_sel_0        = i_tx_mode_sel_0;  // [RL3]
    hw_cfg_d.tx_mode_sel_1        = i_tx_mode_sel_1;  // [RL3]
    hw_cfg_d.tx_mode_sel_2        = i_tx_mode_sel_2;  // [RL3]
    // strapper owns the level; we only capture it
    hw_cfg_d.jitter_clk_sel       = i_alert_pin_in;   // [RL2]
    hw_cfg_d.tx_clk_source_sel    = {i_tx_clk_source_sel_1,
                                     i_bus_pin_in[hpm_pkg::HPM_BIT_TCS0]}; // [RL16]
  end

  // strap capture: first cycle after reset release, then held static
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sampled_q <= 1'b0;
      mode_q    <= hpm_pkg::HPM_MODE_MUX;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      mode_q    <= hpm_pkg::hpm_mode_t'(i_host_port_mode); // [RL18] [RL6]
    end
  end

  // hardware settings sampled once; ignored outside hardware mode
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      hw_cfg_q <= hpm_pkg::HPM_HW_CFG_RESET;
    end else if (!sampled_q &&
                 is_mode(hpm_pkg::hpm_mode_t'(i_host_port_mode), hpm_pkg::HPM_MODE_HW)) begin
      hw_cfg_q <= hw_cfg_d; // [RL18] [RL3]
    end
  end

  // tristate/reset pin: level floats pins, rising edge resets config
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tst_prev_q  <= 1'b0;
      cfg_reset_q <= 1'b0;
      tristate_q  <= 1'b0;
    end else begin
      tst_prev_q  <= i_tristate_and_reset;
      cfg_reset_q <= i_tristate_and_reset & ~tst_prev_q; // [RL4]
      tristate_q  <= i_tristate_and_reset;               // [RL5]
    end
  end

  // host inputs routed by mode; other modes see zeros so the core stays idle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      host_in_q <= '0;
      cs_n_q    <= 1'b1;
    end else begin
      cs_n_q           <= i_chip_select_n; // [RL17]
      host_in_q.bus_in <= (is_mode(mode_q, hpm_pkg::HPM_MODE_MUX) ||
                           is_mode(mode_q, hpm_pkg::HPM_MODE_NONMUX)) ?
                          i_bus_pin_in : hpm_pkg::HPM_BUS_ZERO; // [RL7] [RL8]
      host_in_q.sclk   <= is_mode(mode_q, hpm_pkg::HPM_MODE_SERIAL) &
                          i_bus_pin_in[hpm_pkg::HPM_BIT_SCLK];  // [RL13]
      host_in_q.mosi   <= is_mode(mode_q, hpm_pkg::HPM_MODE_SERIAL) &
                          i_bus_pin_in[hpm_pkg::HPM_BIT_MOSI];  // [RL14]
    end
  end

  // pin drive selection by mode
  always_comb begin
    out_d = hpm_pkg::HPM_BUS_ZERO;
    oe_d  = hpm_pkg::HPM_BUS_ZERO;
    case (mode_q)
      hpm_pkg::HPM_MODE_MUX,
      hpm_pkg::HPM_MODE_NONMUX: begin
        // same lanes in both; the core decides address vs data phase
        out_d = i_core_rd_data;                        // [RL7] [RL8]
        oe_d  = {hpm_pkg::HPM_BUS_W{i_core_rd_drive}}; // [RL7] [RL8]
      end
      hpm_pkg::HPM_MODE_SERIAL: begin
        out_d[hpm_pkg::HPM_BIT_MISO] = i_core_miso;     // [RL15]
        oe_d[hpm_pkg::HPM_BIT_MISO]  = ~i_chip_select_n; // [RL15]
      end
      hpm_pkg::HPM_MODE_HW: begin
        oe_d = hpm_pkg::HPM_BUS_ZERO; // straps only, never driven
      end
      default: begin
        oe_d = hpm_pkg::HPM_BUS_ZERO;
      end
    endcase
    if (i_tristate_and_reset) begin
      oe_d = hpm_pkg::HPM_BUS_ZERO; // [RL5]
    end
    // lanes stay released until the straps are known, so a strap is never overdriven
    if (!sampled_q) begin
      oe_d = hpm_pkg::HPM_BUS_ZERO; // [RL18]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      out_q <= hpm_pkg::HPM_BUS_ZERO;
      oe_q  <= hpm_pkg::HPM_BUS_ZERO;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  // float immediately too, since the registered enable lags one cycle
  assign o_bus_pin_out = out_q;
  assign o_bus_pin_oe  = oe_q & {hpm_pkg::HPM_BUS_W{~i_tristate_and_reset}}; // [RL5]

  // no alert before the straps are known: the pin may still be the jitter strap
  assign alert_event = i_status_event & sampled_q &
                       ~is_mode(mode_q, hpm_pkg::HPM_MODE_HW); // [RL1] [RL18]

  // in hardware mode the pin is a strap input, so the alert never drives it
  hpm_alert_drv u_alert (
    .i_clock       (i_clock),
    .i_reset       (i_reset | cfg_reset_q),
    .i_event       (alert_event), // [RL1]
    .i_tristate    (i_tristate_and_reset),
    .o_alert_n_out (o_alert_n_out), // [RL19]
    .o_alert_n_oe  (o_alert_n_oe)   // [RL19]
  );

  assign o_mode          = mode_q;
  assign o_hw_cfg        = hw_cfg_q;
  assign o_host_in       = host_in_q;
  assign o_chip_select_n = cs_n_q;
  assign o_config_reset  = cfg_reset_q; // [RL4]
  assign o_tristate      = tristate_q;

endmodule : hpm_pin_mux

// ===== verif/hpm_pin_mux_chk.sv
// Purpose: port checker for hpm_pin_mux
// Assumes: straps static once reset is released
// Notes:   live waits out reset and tristate, so stale pipeline state is ignored
`timescale 1ns/1ns
module hpm_pin_mux_chk (
  input wire logic                  i_clock,
  input wire logic                  i_reset,
  input wire logic                  i_tristate_and_reset,
  input wire logic                  i_status_event,
  input wire logic                  i_chip_select_n,
  input wire logic                  i_core_miso,
  input wire logic                  i_core_rd_drive,
  input wire logic [7:0]            i_bus_pin_in,
  input wire logic [7:0]            o_bus_pin_out,
  input wire logic [7:0]            o_bus_pin_oe,
  input wire logic                  o_alert_n_out,
  input wire logic                  o_alert_n_oe,
  input wire hpm_pkg::hpm_mode_t    o_mode,
  input wire hpm_pkg::hpm_host_in_t o_host_in,
  input wire logic                  o_config_reset
);
  logic [1:0] age_q;
  logic       live;
  always_ff @(posedge i_clock) begin
    if (i_reset || i_tristate_and_reset) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  assign live = (age_q == 2'h3) && !i_tristate_and_reset;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence pulse_s;
    $past(i_tristate_and_reset) ##1 !o_config_reset;
  endsequence
  a_alert_event: assert property (live |->
    o_alert_n_oe == ($past(i_status_event) && o_mode != hpm_pkg::HPM_MODE_HW))
    else $error("alert enable does not follow event");
  a_alert_od: assert property (o_alert_n_out == 1'b0)
    else $error("alert pin drives high");
  a_tri_float: assert property (i_tristate_and_reset |->
    o_bus_pin_oe == 8'h00 && !o_alert_n_oe) else $error("drive while tristated");
  a_cfg_cause: assert property ($rose(i_tristate_and_reset) |-> ##[1:2] o_config_reset)
    else $error("no config reset pulse");
  a_cfg_pulse: assert property (o_config_reset |-> pulse_s)
    else $error("config reset pulse wrong");
  a_mode_held: assert property (!$past(i_reset) && !$past(i_reset, 2) |-> $stable(o_mode))
    else $error("mode moved after sampling");
  a_hw_no_drive: assert property (o_mode == hpm_pkg::HPM_MODE_HW |->
    o_bus_pin_oe == 8'h00 && !o_alert_n_oe) else $error("strap pin driven after reset");
  a_par_bus: assert property (live && o_mode inside {hpm_pkg::HPM_MODE_MUX,
    hpm_pkg::HPM_MODE_NONMUX} |-> o_host_in.bus_in == $past(i_bus_pin_in)
    && o_bus_pin_oe == {8{$past(i_core_rd_drive)}}) else $error("parallel lanes wrong");
  a_ser_in: assert property (live && o_mode == hpm_pkg::HPM_MODE_SERIAL |->
    o_host_in.sclk == $past(i_bus_pin_in[2]) && o_host_in.mosi == $past(i_bus_pin_in[1]))
    else $error("serial inputs wrong");
  a_ser_miso: assert property (live && o_mode == hpm_pkg::HPM_MODE_SERIAL &&
    !$past(i_chip_select_n) |-> o_bus_pin_oe[0] && o_bus_pin_out[0] == $past(i_core_miso))
    else $error("serial output wrong");
  a_hw_quiet: assert property (live && o_mode == hpm_pkg::HPM_MODE_HW |->
    o_bus_pin_oe == 8'h00 && !o_alert_n_oe) else $error("drive in strap mode");
endmodule : hpm_pin_mux_chk

// ===== verif/hpm_host_model.sv
// Purpose: host and strap side of the shared pins
// Assumes: alert wire has a pull-up, bus wires have none
// Notes:   an undriven bus lane shows the inverse of its last level
`timescale 1ns/1ns
module hpm_host_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_bus_out,
  input  wire logic [7:0] i_bus_oe,
  input  wire logic       i_alert_out,
  input  wire logic       i_alert_oe,
  input  wire logic [7:0] i_host_val,
  input  wire logic [7:0] i_host_en,
  input  wire logic       i_jit_strap,
  output logic      [7:0] o_bus_lvl,
  output logic            o_alert_lvl
);
  logic [7:0] last_q;
  always_ff @(posedge i_clock) begin
    last_q <= o_bus_lvl;
  end
  assign o_bus_lvl = (i_bus_oe & i_bus_out) | (~i_bus_oe & i_host_en & i_host_val)
                   | (~i_bus_oe & ~i_host_en & ~last_q);
  // strap low pulls the wire down, else the pull-up wins
  assign o_alert_lvl = i_alert_oe ? i_alert_out : i_jit_strap;
endmodule : hpm_host_model

// ===== verif/hpm_pin_mux_tb_top.sv
// Purpose: directed bench for hpm_pin_mux
// Assumes: inputs move and outputs are read at the falling edge
// Notes:   straps only count at reset release, so each mode gets its own reset
`timescale 1ns/1ns
bind hpm_pin_mux hpm_pin_mux_chk chk_i (.*);
module hpm_pin_mux_tb_top;
  logic i_clock, i_reset, i_tristate_and_reset, i_tx_mode_sel_0, i_tx_mode_sel_1;
  logic i_tx_mode_sel_2, i_tx_clk_source_sel_1, i_chip_select_n, i_alert_pin_in;
  logic i_status_event, i_core_rd_drive, i_core_miso, o_alert_n_out, o_alert_n_oe;
  logic o_chip_select_n, o_config_reset, o_tristate, jit;
  logic [1:0] i_host_port_mode;
  logic [7:0] i_bus_pin_in, o_bus_pin_out, o_bus_pin_oe, i_core_rd_data, h_val, h_en;
  hpm_pkg::hpm_mode_t    o_mode;
  hpm_pkg::hpm_hw_cfg_t  o_hw_cfg;
  hpm_pkg::hpm_host_in_t o_host_in;
  int err_total = 0;
  int checks = 0;
  hpm_pin_mux dut (.*);
  hpm_host_model host (.i_clock(i_clock), .i_bus_out(o_bus_pin_out), .i_bus_oe(o_bus_pin_oe),
    .i_alert_out(o_alert_n_out), .i_alert_oe(o_alert_n_oe), .i_host_val(h_val),
    .i_host_en(h_en), .i_jit_strap(jit), .o_bus_lvl(i_bus_pin_in), .o_alert_lvl(i_alert_pin_in));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge i_clock);
  endtask : step
  task automatic end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic start(input logic [1:0] m);
    i_host_port_mode = m;
    i_reset = 1'b1;
    step(3);
    chk("rst_cs", 1'b1, o_chip_select_n);
    i_reset = 1'b0;
    step(3);
  endtask : start
  task automatic wait_pulse;
    int n;
    n = 0;
    while (o_config_reset !== 1'b1 && n < 4) begin
      step(1);
      n++;
    end
    chk("cfg_pulse", 1'b1, o_config_reset);
    if (n == 4)
      end_sim();
    step(1);
    chk("cfg_pulse_end", 1'b0, o_config_reset);
  endtask : wait_pulse
  initial begin
    {i_reset, i_tristate_and_reset, i_tx_mode_sel_1, i_tx_clk_source_sel_1} = 4'h8;
    {i_tx_mode_sel_2, i_tx_mode_sel_0, i_status_event, i_chip_select_n} = 4'hF;
    {i_core_rd_drive, i_core_miso, i_host_port_mode} = 4'h0;
    i_core_rd_data = 8'h3C;
    jit = 1'b1; // high-rate master clock in T1
    for (int m = 0; m < 4; m++) begin
      h_val = 8'hA5;
      h_en = 8'hFF;
      start(m[1:0]);
      chk("mode", m[1:0], o_mode);
      if (m < 2) begin
        chk("bus_in", 8'hA5, o_host_in.bus_in);
        chk("alert_lvl", 1'b0, i_alert_pin_in);
        h_en = 8'h00;
        i_core_rd_drive = 1'b1;
        step(2);
        chk("bus_lvl", 8'h3C, i_bus_pin_in);
        i_tristate_and_reset = 1'b1;
        #1;
        chk("tri_oe", 9'h000, {o_alert_n_oe, o_bus_pin_oe});
        wait_pulse();
        chk("tri_copy", 1'b1, o_tristate);
        i_tristate_and_reset = 1'b0; // normal operation
        i_core_rd_drive = 1'b0;
      end else if (m == 2) begin
        h_en = 8'hFE;
        h_val = 8'h04;
        i_core_miso = 1'b1;
        i_chip_select_n = 1'b0;
        step(2);
        chk("sclk_mosi", 2'h2, {o_host_in.sclk, o_host_in.mosi});
        chk("cs_copy", 1'b0, o_chip_select_n);
        chk("miso_hi", 1'b1, i_bus_pin_in[0]);
        i_core_miso = 1'b0;
        step(1);
        chk("miso_lo", 1'b0, i_bus_pin_in[0]);
        i_chip_select_n = 1'b1;
      end else begin
        // fields in order: term rx/tx, rx mode 3/1/0, sync t/r, tx mode 2/1/0, jitter, clk src
        chk("hw_cfg", 13'h126D, o_hw_cfg);
        h_val = 8'h5A;
        i_tx_mode_sel_2 = 1'b0;
        step(2);
        chk("hw_held", 13'h126D, o_hw_cfg);
        chk("hw_quiet", 9'h000, {o_alert_n_oe, o_bus_pin_oe});
      end
    end
    end_sim();
  end
endmodule : hpm_pin_mux_tb_top
